// ---- common/ssfs_pkg.sv ----
// Package for the soft-start and fault sequencer: timing counts, thresholds, states.
// Assumes one phase clock domain; analog comparators arrive as digital levels.
package ssfs_pkg;
    // Delay from all start conditions true to soft-start begin, in phase clocks.
    localparam int unsigned START_DELAY_CYCLES = 384;
    // Full soft-start ramp length in switching cycles.
    localparam int unsigned SOFT_START_CYCLES = 2560;
    // Gate turn-off bound on shutdown, and its cycle count at 200 MHz (rounded down).
    localparam int unsigned OFF_TIME_NS = 100;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned OFF_TIME_CYCLES = OFF_TIME_NS / CLK_PERIOD_NS;
    // Consecutive fault cycles before the power-ok flag drops.
    localparam logic [1:0] PG_FILTER_CYCLES = 2'h3;

    // Output window comparator levels, one bit each.
    typedef struct packed {
        logic above_120; // Output above 120 percent of target.
        logic above_113; // Output above 113 percent of target.
        logic above_target; // Output above the target level.
        logic below_87; // Output below 87 percent of target.
        logic below_uv; // Output more than 13 percent below target.
    } ssfs_window_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        SSFS_OFF,
        SSFS_WAIT,
        SSFS_PRECHG,
        SSFS_BOOT,
        SSFS_RAMP,
        SSFS_RUN,
        SSFS_LATCHED
    } ssfs_state_t;
endpackage

// ---- hdl/ssfs_sequencer.sv ----
// Soft-start, power-ok and protection sequencer for a step-down controller.
// Assumes CLK_SYS is the phase clock and RST_N is the bias supply power-on reset.
// Behaviour
// - Start ramp 384 clocks after enable, supplies and loop lock are all good.
// - Shutdown or supply loss resets ramp and turns both drives off quickly.
// - Sink current on the enable line only in the off and start-delay states.
// - Ramp counter steps once per phase clock, 2560 steps full scale.
// - Hold modulator pulses from drivers until the first pulse is seen.
// - Hold low-side drive in its fixed state for the first switching cycle.
// - Pre-charge between target and 113 percent waits for target and first pulse.
// - Pre-charge 113 to 120 percent with enable low hiccups low-side 113 on, 87 off.
// - Pre-charge above 120 percent latches off and refuses start-up.
// - Power-ok stays low until the ramp has completed.
// - Power-ok drops on disable or when output leaves the window.
// - Power-ok drops after a window fault lasts three consecutive cycles; leaving run drops it at once.
// - Undervoltage masked until ramp end, then drops power-ok if nothing else.
// - Above 120 percent from pre-charge to run: high-side off for good, low-side on until below 87.
// - Latching overvoltage also forces enable line and power-ok low, latched.
// - Overvoltage latch clears only by bias supply power cycle.
// - Enable low and above 113 percent turns low-side on until below 87 or enable high.
// - Temperature above 150 C pulls enable low, released below 125 C.
// - Overvoltage latch or over-temperature pulls the shared enable low; low enable disables.
`timescale 1ns/1ps

module ssfs_sequencer
    import ssfs_pkg::*;
#(
    parameter int unsigned START_DELAY = START_DELAY_CYCLES, // Start delay in clocks.
    parameter int unsigned RAMP_LEN = SOFT_START_CYCLES // Ramp length in clocks.
)
(
    input wire logic CLK_SYS, // Phase clock, 200 MHz.
    input wire logic RST_N, // Bias supply power-on reset, active low.
    input wire logic SUPPLY_OK, // All bias supplies above power-on threshold.
    input wire logic ENABLE_LEVEL, // Shared enable line above 0.8 V.
    input wire logic LOOP_LOCK, // Loop lock time has elapsed.
    input wire logic OVER_TEMP_HI, // Die temperature above 150 C.
    input wire logic OVER_TEMP_LO, // Die temperature below 125 C.
    input wire ssfs_window_t OUT_WINDOW, // Output monitor comparator levels.
    input wire logic PWM_IN, // Modulator pulse from the loop.
    output logic HIGH_SIDE_DRIVE, // High-side gate drive, active high.
    output logic LOW_SIDE_DRIVE, // Low-side gate drive, active high.
    output logic ENABLE_PULL_OE, // Pulls shared enable line low when high.
    output logic ENABLE_SINK_ON, // Enables the enable-line sink current.
    output logic POWER_OK_FLAG, // Power-ok, active high.
    output logic [11:0] RAMP_REF, // Soft-start reference count.
    output logic RAMP_DONE // Soft-start complete indication.
);
    localparam int unsigned CW = 12;

    // Two-stage synchronisers; the first stage feeds only the second.
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] raw_in;
    assign raw_in = {SUPPLY_OK, ENABLE_LEVEL, LOOP_LOCK, OVER_TEMP_HI, OVER_TEMP_LO,
                     OUT_WINDOW, PWM_IN};
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sync1 <= 11'h000;
            sync2 <= 11'h000;
        end
        else
        begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end

    logic s_supply, s_en, s_lock, s_ot_hi, s_ot_lo, s_pwm;
    ssfs_window_t s_win;
    assign {s_supply, s_en, s_lock, s_ot_hi, s_ot_lo, s_win, s_pwm} = sync2;

    // Sequencer state and counters.
    ssfs_state_t state, next_state;
    logic [CW-1:0] count, next_count;
    logic ov_latch, next_ov_latch;
    logic ov_low_on, next_ov_low_on;
    logic ot_fault, next_ot_fault;
    logic hic_low_on, next_hic_low_on;
    logic [1:0] pg_cnt, next_pg_cnt;
    logic pg, next_pg;
    logic next_hs;
    logic next_ls;
    logic start_ok;
    logic run_ok;
    logic pg_fault;

    // Start conditions; the shared enable reads low whenever anyone pulls it.
    assign start_ok = s_en && s_supply && s_lock;
    assign run_ok = start_ok && !ov_latch && !ot_fault;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_ov_latch = ov_latch;
        next_ov_low_on = ov_low_on;
        next_ot_fault = ot_fault;
        next_hic_low_on = hic_low_on;
        // Temperature hysteresis on the shared enable pull.
        if (s_ot_hi)
            next_ot_fault = 1'b1;
        else if (s_ot_lo)
            next_ot_fault = 1'b0;
        // Latching overvoltage from pre-charge onward, never released here.
        if (s_win.above_120 && (state == SSFS_RAMP || state == SSFS_RUN ||
                                state == SSFS_BOOT || state == SSFS_PRECHG))
        begin
            next_ov_latch = 1'b1;
            next_ov_low_on = 1'b1;
        end
        else if (ov_low_on && s_win.below_87)
            next_ov_low_on = 1'b0;
        // Non-latching low-side clamp while enable is low.
        if (!s_en && s_win.above_113)
            next_hic_low_on = 1'b1;
        else if (s_win.below_87 || s_en)
            next_hic_low_on = 1'b0;
        case (state)
            SSFS_OFF:
            begin
                next_count = '0;
                if (start_ok && s_win.above_120)
                begin
                    next_state = SSFS_LATCHED;
                    next_ov_latch = 1'b1;
                end
                else if (run_ok)
                    next_state = SSFS_WAIT;
            end
            SSFS_WAIT:
            begin
                if (!run_ok)
                begin
                    next_state = SSFS_OFF;
                    next_count = '0;
                end
                else if (count == CW'(START_DELAY - 1))
                begin
                    next_count = '0;
                    next_state = SSFS_PRECHG;
                end
                else
                    next_count = count + 1'b1;
            end
            SSFS_PRECHG:
            begin
                // Pre-charged output: wait for it to fall to target and a pulse.
                if (!run_ok)
                    next_state = SSFS_OFF;
                else if (!s_win.above_target && s_pwm)
                    next_state = SSFS_BOOT;
            end
            SSFS_BOOT:
                next_state = run_ok ? SSFS_RAMP : SSFS_OFF;
            SSFS_RAMP:
            begin
                if (!run_ok)
                begin
                    next_state = SSFS_OFF;
                    next_count = '0;
                end
                else if (count == CW'(RAMP_LEN - 1))
                    next_state = SSFS_RUN;
                else
                    next_count = count + 1'b1;
            end
            SSFS_RUN:
            begin
                if (!run_ok)
                begin
                    next_state = SSFS_OFF;
                    next_count = '0;
                end
            end
            SSFS_LATCHED:
                next_state = SSFS_LATCHED;
            default:
                next_state = SSFS_OFF;
        endcase
        if (next_ov_latch)
            next_state = SSFS_LATCHED;
    end

    // Power-ok filter: a window fault must persist three cycles before the drop; leaving run drops it at once.
    assign pg_fault = !s_en || s_win.above_113 || (s_win.below_uv && !ot_fault);
    always_comb
    begin
        next_pg_cnt = pg_cnt;
        next_pg = pg;
        // Leaving the run state clears the flag in the same edge as the done indication.
        if (ov_latch || state != SSFS_RUN || next_state != SSFS_RUN)
        begin
            next_pg = 1'b0;
            next_pg_cnt = 2'h0;
        end
        else if (pg_fault)
        begin
            if (pg_cnt == PG_FILTER_CYCLES - 2'h1)
                next_pg = 1'b0;
            else
                next_pg_cnt = pg_cnt + 2'h1;
        end
        else
        begin
            next_pg_cnt = 2'h0;
            next_pg = 1'b1;
        end
    end

    // Gate drive: pulses pass only once switching has begun; fault clamps win.
    always_comb
    begin
        next_hs = 1'b0;
        next_ls = 1'b0;
        if (ov_low_on || hic_low_on)
            next_ls = 1'b1;
        else if (state == SSFS_BOOT)
            next_ls = 1'b1;
        else if ((state == SSFS_RAMP || state == SSFS_RUN) && run_ok)
        begin
            next_hs = s_pwm;
            next_ls = !s_pwm;
        end
        if (ov_latch || !s_supply)
            next_hs = 1'b0;
    end

    // All sequencer state registers.
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state <= SSFS_OFF;
            count <= '0;
            ov_latch <= 1'b0;
            ov_low_on <= 1'b0;
            ot_fault <= 1'b0;
            hic_low_on <= 1'b0;
            pg_cnt <= 2'h0;
            pg <= 1'b0;
            HIGH_SIDE_DRIVE <= 1'b0;
            LOW_SIDE_DRIVE <= 1'b0;
            ENABLE_PULL_OE <= 1'b0;
            ENABLE_SINK_ON <= 1'b1;
            POWER_OK_FLAG <= 1'b0;
            RAMP_REF <= 12'h000;
            RAMP_DONE <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            ov_latch <= next_ov_latch;
            ov_low_on <= next_ov_low_on;
            ot_fault <= next_ot_fault;
            hic_low_on <= next_hic_low_on;
            pg_cnt <= next_pg_cnt;
            pg <= next_pg;
            HIGH_SIDE_DRIVE <= next_hs;
            LOW_SIDE_DRIVE <= next_ls;
            ENABLE_PULL_OE <= next_ov_latch || next_ot_fault;
            ENABLE_SINK_ON <= (next_state == SSFS_OFF) || (next_state == SSFS_WAIT);
            POWER_OK_FLAG <= next_pg;
            RAMP_REF <= (next_state == SSFS_RUN) ? CW'(RAMP_LEN) : next_count;
            RAMP_DONE <= (next_state == SSFS_RUN);
        end
    end

    // Power-ok never high before the ramp completes.
    property p_pg_after_ramp;
        @(posedge CLK_SYS) disable iff (!RST_N) POWER_OK_FLAG |-> RAMP_DONE;
    endproperty
    a_pg_after_ramp: assert property (p_pg_after_ramp) else $error("Power-ok before ramp done.");

    // High side stays off once the latch is set.
    property p_hs_latched;
        @(posedge CLK_SYS) disable iff (!RST_N) ov_latch |=> !HIGH_SIDE_DRIVE;
    endproperty
    a_hs_latched: assert property (p_hs_latched) else $error("High side on after overvoltage.");

    // Latch never clears without reset.
    property p_latch_sticky;
        @(posedge CLK_SYS) disable iff (!RST_N) ov_latch |=> ov_latch;
    endproperty
    a_latch_sticky: assert property (p_latch_sticky) else $error("Overvoltage latch released.");

    // Latch forces enable pull and power-ok low.
    property p_latch_pulls;
        @(posedge CLK_SYS) disable iff (!RST_N) ov_latch |-> ENABLE_PULL_OE && !POWER_OK_FLAG;
    endproperty
    a_latch_pulls: assert property (p_latch_pulls) else $error("Latch without enable pull.");

    // A drop in steady running needs three fault cycles in a row before it.
    property p_pg_filter;
        @(posedge CLK_SYS) disable iff (!RST_N)
            $fell(POWER_OK_FLAG) && $past(state) == SSFS_RUN
            && $past(next_state) == SSFS_RUN
            |-> $past(pg_fault) && $past(pg_fault, 2) && $past(pg_fault, 3);
    endproperty
    a_pg_filter: assert property (p_pg_filter) else $error("Power-ok filter broken.");

    // Ramp entry only from the boot cycle.
    property p_boot_first;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (state == SSFS_RAMP) && $changed(state) |-> $past(state) == SSFS_BOOT;
    endproperty
    a_boot_first: assert property (p_boot_first) else $error("Ramp without boot cycle.");

    // Low side held during the boot cycle.
    property p_boot_low;
        @(posedge CLK_SYS) disable iff (!RST_N) state == SSFS_BOOT |=> LOW_SIDE_DRIVE;
    endproperty
    a_boot_low: assert property (p_boot_low) else $error("Low side not held at boot.");

    // Supply loss turns the high side off within the bound.
    property p_supply_off;
        @(posedge CLK_SYS) disable iff (!RST_N) $fell(SUPPLY_OK) |-> ##[1:4] !HIGH_SIDE_DRIVE;
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("High side slow to stop.");

    // Sink current off while running.
    property p_sink_off;
        @(posedge CLK_SYS) disable iff (!RST_N) RAMP_DONE |-> !ENABLE_SINK_ON;
    endproperty
    a_sink_off: assert property (p_sink_off) else $error("Sink on while enabled.");
endmodule // ssfs_sequencer

// ---- sim/ssfs_enable_bus.sv ----
// Model of the shared enable line with paralleled peer modules on it.
// Assumes an external pull-up; any party on the wired-OR line may pull it low.
`timescale 1ns/1ps

module ssfs_enable_bus
(
    input wire logic sys_en, // System enable before any pull-down.
    input wire logic own_pull, // Pull-down from the module under test.
    input wire logic peer_pull, // Pull-down from a paralleled peer on its own fault.
    output logic enable_level // Line level above the enable threshold.
);
    // One pull from anybody disables every module, so all of them stop together.
    assign enable_level = sys_en & ~own_pull & ~peer_pull;
endmodule // ssfs_enable_bus

// ---- sim/ssfs_sequencer_tb.sv ----
// Self-checking bench for the soft-start and fault sequencer.
// Assumes shortened start and ramp counts; the enable line comes from the bus model.
`timescale 1ns/1ps

module ssfs_sequencer_tb
    import ssfs_pkg::*;
;
    localparam int SD = 8;
    localparam int RL = 16;
    logic clk_sys, rst_n, supply_ok, loop_lock, ot_hi, ot_lo, pwm_in, sys_en, peer_pull;
    logic enable_level, hs, ls, pull_oe, sink_on, pok, done;
    logic [11:0] ramp_ref;
    ssfs_window_t win;
    int n_errors = 0;
    int checked = 0;
    int t;

    // Clock at 200 MHz.
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    ssfs_enable_bus u_bus (.sys_en(sys_en), .own_pull(pull_oe), .peer_pull(peer_pull),
        .enable_level(enable_level));

    ssfs_sequencer #(.START_DELAY(SD), .RAMP_LEN(RL)) u_dut (.CLK_SYS(clk_sys),
        .RST_N(rst_n), .SUPPLY_OK(supply_ok), .ENABLE_LEVEL(enable_level),
        .LOOP_LOCK(loop_lock), .OVER_TEMP_HI(ot_hi), .OVER_TEMP_LO(ot_lo),
        .OUT_WINDOW(win), .PWM_IN(pwm_in), .HIGH_SIDE_DRIVE(hs), .LOW_SIDE_DRIVE(ls),
        .ENABLE_PULL_OE(pull_oe), .ENABLE_SINK_ON(sink_on), .POWER_OK_FLAG(pok),
        .RAMP_REF(ramp_ref), .RAMP_DONE(done));

    // Verdict and end of run; also reached from the watchdog.
    task automatic print_verdict();
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        checked++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    function automatic logic sel(input int i);
        case (i)
            0: return ls;
            1: return hs;
            2: return done;
            3: return pok;
            4: return pull_oe;
            default: return sink_on;
        endcase
    endfunction

    // Bounded wait on an output; t keeps the number of edges it took.
    task automatic expect_sig(input string n, input int i, input logic v, input int lim);
        #1;
        t = 0;
        while (sel(i) !== v && t < lim)
        begin
            tick(1);
            t++;
        end
        chk(n, 12'(v), 12'(sel(i)));
    endtask

    // Raise every start condition; an optional pre-charge above target must hold it off.
    task automatic start_up(input logic pre);
        @(posedge clk_sys);
        supply_ok <= 1'b1;
        loop_lock <= 1'b1;
        sys_en <= 1'b1;
        pwm_in <= 1'b1;
        win.above_target <= pre;
        if (pre)
        begin
            tick(SD + 20);
            chk("drv_prechg", 12'h0, {10'h0, hs, ls});
            @(posedge clk_sys);
            win.above_target <= 1'b0;
        end
        expect_sig("ls_boot", 0, 1'b1, SD + 20);
    endtask

    // Random pulses through the ramp; power-ok must wait for the final count.
    task automatic run_ramp();
        t = 0;
        while (done !== 1'b1 && t < RL + 20)
        begin
            @(posedge clk_sys);
            pwm_in <= 1'($urandom % 2);
            #1;
            t++;
            if (done !== 1'b1)
                chk("pok_ramp", 12'h0, 12'(pok));
        end
        chk("ramp_len", 12'h1, 12'((t >= RL - 1) && (t <= RL + 4)));
        chk("ramp_ref", 12'(RL), ramp_ref);
        expect_sig("pok_up", 3, 1'b1, 4);
    endtask

    initial
    begin
        {supply_ok, loop_lock, ot_hi, pwm_in, sys_en, peer_pull} = 6'h0;
        ot_lo = 1'b1;
        win = '0;
        rst_n = 1'b0;
        void'($urandom(56));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        tick(1);
        chk("sink_rst", 12'h1, 12'(sink_on));
        chk("drv_rst", 12'h0, {10'h0, hs, ls});
        chk("pok_rst", 12'h0, 12'(pok));
        start_up(1'b0);
        chk("delay", 12'h1, 12'((t >= SD) && (t <= SD + 8)));
        run_ramp();
        chk("sink_en", 12'h0, 12'(sink_on));
        // Short under-voltage glitches are filtered, a lasting one drops the flag.
        repeat (4)
        begin
            @(posedge clk_sys);
            win.below_uv <= 1'b1;
            tick($urandom % 2);
            @(posedge clk_sys);
            win.below_uv <= 1'b0;
            tick(4);
            chk("pok_glitch", 12'h1, 12'(pok));
        end
        @(posedge clk_sys);
        win.below_uv <= 1'b1;
        expect_sig("pok_uv", 3, 1'b0, 9);
        chk("uv_filter", 12'h1, 12'(t >= 3));
        @(posedge clk_sys);
        win.below_uv <= 1'b0;
        pwm_in <= 1'b1;
        tick(8);
        // A peer pulls the shared line low: everything stops together.
        @(posedge clk_sys);
        peer_pull <= 1'b1;
        expect_sig("hs_off", 1, 1'b0, OFF_TIME_CYCLES);
        chk("ls_off", 12'h0, 12'(ls));
        expect_sig("pok_dis", 3, 1'b0, 8);
        chk("ref_clr", 12'h0, ramp_ref);
        @(posedge clk_sys);
        win.above_113 <= 1'b1;
        expect_sig("clamp_on", 0, 1'b1, 8);
        @(posedge clk_sys);
        win.above_113 <= 1'b0;
        win.below_87 <= 1'b1;
        expect_sig("clamp_off", 0, 1'b0, 8);
        @(posedge clk_sys);
        win.below_87 <= 1'b0;
        peer_pull <= 1'b0;
        // Peer released: start up and ramp again before the supply-loss test.
        start_up(1'b0);
        run_ramp();
        // Supply loss in mid-run stops both drives and clears the ramp.
        @(posedge clk_sys);
        pwm_in <= 1'b1;
        tick(4);
        chk("hs_run", 12'h1, 12'(hs));
        @(posedge clk_sys);
        supply_ok <= 1'b0;
        expect_sig("hs_supply", 1, 1'b0, OFF_TIME_CYCLES);
        tick(1);
        chk("supply_off", 12'h0, {9'h0, ls, pok, done});
        start_up(1'b0);
        run_ramp();
        @(posedge clk_sys);
        ot_hi <= 1'b1;
        ot_lo <= 1'b0;
        expect_sig("ot_pull", 4, 1'b1, 6);
        expect_sig("ot_pok", 3, 1'b0, 8);
        @(posedge clk_sys);
        ot_hi <= 1'b0;
        tick(10);
        chk("ot_hold", 12'h1, 12'(pull_oe));
        @(posedge clk_sys);
        ot_lo <= 1'b1;
        expect_sig("ot_rel", 4, 1'b0, 6);
        // Latching overvoltage in mid-ramp after a pre-charged start.
        start_up(1'b1);
        @(posedge clk_sys);
        win.above_120 <= 1'b1;
        pwm_in <= 1'b1;
        expect_sig("ov_ls", 0, 1'b1, 6);
        chk("ov_hs", 12'h0, 12'(hs));
        expect_sig("ov_pull", 4, 1'b1, 6);
        expect_sig("ov_pok", 3, 1'b0, 8);
        @(posedge clk_sys);
        win.above_120 <= 1'b0;
        win.below_87 <= 1'b1;
        sys_en <= 1'b0;
        expect_sig("ov_ls_off", 0, 1'b0, 8);
        @(posedge clk_sys);
        win.below_87 <= 1'b0;
        sys_en <= 1'b1;
        tick(SD + RL + 20);
        chk("ov_latch", 12'h4, {9'h0, pull_oe, hs, done});
        // Only a power cycle clears it; a pre-charge above the top level refuses start.
        @(posedge clk_sys);
        rst_n <= 1'b0;
        win.above_120 <= 1'b1;
        tick(2);
        chk("ov_clear", 12'h0, 12'(pull_oe));
        @(posedge clk_sys);
        rst_n <= 1'b1;
        tick(SD + RL + 30);
        chk("prechg_lock", 12'h4, {9'h0, pull_oe, hs, done});
        print_verdict();
    end

    // Watchdog well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end
endmodule // ssfs_sequencer_tb
